// ### spc_pkg.sv
// package: constants, types and structs for the segment privilege checker
package spc_pkg;

    // -------------------------------------------------------------------
    // privilege encoding
    // -------------------------------------------------------------------
    typedef logic [1:0] spc_priv_t;
    localparam spc_priv_t SPC_PRIV_MOST  = 2'h0;
    localparam spc_priv_t SPC_PRIV_LEAST = 2'h3;
    localparam spc_priv_t SPC_CPL_RESET  = 2'h0;
    localparam logic [15:0] SPC_V86_LIMIT = 16'hFFFF;

    // -------------------------------------------------------------------
    // register bus map (own choice of offsets)
    // -------------------------------------------------------------------
    localparam logic [3:0] SPC_OFS_MODE   = 4'h0;
    localparam logic [3:0] SPC_OFS_STATUS = 4'h1;
    localparam logic [3:0] SPC_OFS_FLAGS  = 4'h2;
    localparam logic [3:0] SPC_OFS_STK0   = 4'h4;
    localparam logic [3:0] SPC_OFS_SEL0   = 4'h8;
    localparam logic [3:0] SPC_OFS_MAPLO  = 4'hC;
    localparam logic [3:0] SPC_OFS_MAPHI  = 4'hD;
    localparam int SPC_MODE_PE_BIT  = 0;
    localparam int SPC_MODE_V86_BIT = 1;
    localparam int SPC_MODE_TSS32_BIT = 2;
    localparam int SPC_FLAGS_IO_PRIVILEGE_THRESHOLD_LSB = 12;
    localparam int SPC_FLAGS_NT_BIT   = 14;
    localparam logic [31:0] SPC_READ_UNMAPPED = 32'h0000_0000;

    // -------------------------------------------------------------------
    // I/O permission bitmap
    // -------------------------------------------------------------------
    localparam int SPC_IOMAP_AW = 10;
    localparam int SPC_IOMAP_WORDS = 1 << SPC_IOMAP_AW;

    // -------------------------------------------------------------------
    // operations, descriptor kinds, tables
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        SPC_OP_NONE  = 4'h0,
        SPC_OP_DATA  = 4'h1,
        SPC_OP_JMP   = 4'h2,
        SPC_OP_CALL  = 4'h3,
        SPC_OP_RET   = 4'h4,
        SPC_OP_IRET  = 4'h5,
        SPC_OP_INTR  = 4'h6,
        SPC_OP_IO    = 4'h7,
        SPC_OP_IFMOD = 4'h8
    } spc_op_t;

    typedef enum logic [2:0] {
        SPC_DESC_DATA  = 3'h0,
        SPC_DESC_CODE  = 3'h1,
        SPC_DESC_CGATE = 3'h2,
        SPC_DESC_IGATE = 3'h3,
        SPC_DESC_TGATE = 3'h4,
        SPC_DESC_TSS   = 3'h5,
        SPC_DESC_OTHER = 3'h6
    } spc_desc_t;

    typedef enum logic [1:0] {
        SPC_TBL_GDT = 2'h0,
        SPC_TBL_LDT = 2'h1,
        SPC_TBL_IDT = 2'h2
    } spc_tbl_t;

    typedef enum logic [1:0] {
        SPC_ST_IDLE  = 2'h0,
        SPC_ST_IOMAP = 2'h1
    } spc_state_t;

    // -------------------------------------------------------------------
    // request and answer carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic      valid;
        spc_op_t   op;
        spc_priv_t requested_privilege;
        spc_priv_t descriptor_privilege;
        spc_desc_t desc;
        spc_tbl_t  tbl;
        spc_priv_t tgt_dpl;
        logic [15:0] port;
    } spc_req_t;

    typedef struct packed {
        logic        done;
        logic        allow;
        logic        gp_fault;
        logic        stack_switch;
        logic [15:0] new_ss;
        logic [31:0] new_sp;
        logic        push_old_sp;
    } spc_rsp_t;

endpackage : spc_pkg

// ### spc_iomap.sv
// memory holding the I/O permission bitmap, registered read
`timescale 1ns/10ps
module spc_iomap (
    input  wire logic                            clock,
    input  wire logic                            ce,
    input  wire logic                            we,
    input  wire logic [spc_pkg::SPC_IOMAP_AW-1:0] waddr,
    input  wire logic [63:0]                     wdata,
    input  wire logic [spc_pkg::SPC_IOMAP_AW-1:0] raddr,
    output logic      [63:0]                     rdata
);
    import spc_pkg::*;

    logic [63:0] mem [SPC_IOMAP_WORDS];

    always_ff @(posedge clock)
    begin
        if (ce)
        begin
            if (we)
                mem[waddr] <= wdata;
            rdata <= mem[raddr];
        end
    end
endmodule : spc_iomap

// ### spc_stack_tbl.sv
// per-level stack selector and pointer table for levels 0 to 2
`timescale 1ns/10ps
module spc_stack_tbl (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              we,
    input  wire logic [1:0]        wlvl,
    input  wire logic              wsel,
    input  wire logic [31:0]       wdata,
    input  wire spc_pkg::spc_priv_t rlvl,
    output logic      [15:0]       ss,
    output logic      [31:0]       sp
);
    import spc_pkg::*;

    typedef struct packed {
        logic [2:0][15:0] ss;
        logic [2:0][31:0] sp;
    } spc_stk_state_t;

    spc_stk_state_t s_q;
    spc_stk_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (we && wlvl != 2'h3)
        begin
            if (wsel)
                s_d.ss[wlvl] = wdata[15:0];
            else
                s_d.sp[wlvl] = wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign ss = (rlvl == 2'h3) ? 16'h0000 : s_q.ss[rlvl];
    assign sp = (rlvl == 2'h3) ? 32'h0000_0000 : s_q.sp[rlvl];
endmodule : spc_stack_tbl

// ### spc_checker.sv
// segment privilege checker top: effective level, access, gate, I/O and transfer checks
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module spc_checker (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [3:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    input  wire spc_pkg::spc_req_t req,
    output spc_pkg::spc_rsp_t      rsp,
    output logic                   busy,
    output spc_pkg::spc_priv_t     cur_priv,
    output logic                   protected_mode,
    output logic [15:0]            seg_limit_v86,
    output logic                   v86_limit_force
);
    import spc_pkg::*;

    // -------------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------------
    logic [1:0] rsync_q;
    logic       rst_sync_n;

    // runs free of ce so a frozen core still leaves reset in two edges
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rsync_q <= 2'h0;
        else
            rsync_q <= {rsync_q[0], 1'b1};
    end
    assign rst_sync_n = rsync_q[1];

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic spc_priv_t max_priv(input spc_priv_t a, input spc_priv_t b);
        max_priv = (a > b) ? a : b;
    endfunction : max_priv

    function automatic logic in_gl(input spc_tbl_t t);
        in_gl = (t == SPC_TBL_GDT) || (t == SPC_TBL_LDT);
    endfunction : in_gl

    function automatic logic gate_ok(input spc_priv_t e, input spc_priv_t d);
        gate_ok = (e <= d);
    endfunction : gate_ok

    function automatic logic io_sensitive(input spc_op_t op);
        io_sensitive = (op == SPC_OP_IO) || (op == SPC_OP_IFMOD);
    endfunction : io_sensitive

    function automatic logic stack_slot(input logic [3:0] a);
        stack_slot = (a[3:2] == 2'h1) || (a[3:2] == 2'h2);
    endfunction : stack_slot

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        spc_state_t  st;
        logic        pe;
        logic        v86;
        logic        tss32;
        spc_priv_t   current_privilege;
        spc_priv_t   io_privilege_threshold;
        logic        nt;
        logic [15:0] port;
        logic        pend_ret;
        spc_rsp_t    rsp;
        logic [31:0] rdata;
        logic        map_we;
        logic [SPC_IOMAP_AW-1:0] map_waddr;
        logic [63:0] map_wdata;
        logic [31:0] map_lo;
    } spc_state_s_t;

    spc_state_s_t s_q;
    spc_state_s_t s_d;

    logic [63:0] map_rdata;
    logic [15:0] stk_ss;
    logic [31:0] stk_sp;
    spc_priv_t   cpl_eff;
    spc_priv_t   effective_privilege;
    spc_priv_t   new_cpl;
    logic        ok;
    logic        lvl_chg;
    logic        io_clear;
    logic        map_bit;
    logic        io_op;
    logic        stk_we;
    logic        gate_dir_ok;

    // -------------------------------------------------------------------
    // decisions
    // -------------------------------------------------------------------
    assign cpl_eff = !s_q.pe ? SPC_PRIV_MOST :
                     (s_q.v86 ? SPC_PRIV_LEAST : s_q.current_privilege);
    assign effective_privilege     = max_priv(req.requested_privilege, cpl_eff);
    assign io_clear = (cpl_eff <= s_q.io_privilege_threshold);
    assign map_bit = map_rdata[s_q.port[5:0]];
    assign io_op       = io_sensitive(req.op);
    assign stk_we      = wr && stack_slot(addr);
    // a call or interrupt gate only leads to the same or a more privileged level
    assign gate_dir_ok = (req.tgt_dpl <= cpl_eff);

    // -------------------------------------------------------------------
    // transfer descriptor check
    // -------------------------------------------------------------------
    always_comb
    begin
        ok      = 1'b0;
        lvl_chg = 1'b0;
        new_cpl = s_q.current_privilege;
        unique case (req.op)
            SPC_OP_DATA:
                ok = (req.desc == SPC_DESC_DATA || req.desc == SPC_DESC_CODE)
                     && (effective_privilege <= req.descriptor_privilege);
            SPC_OP_JMP, SPC_OP_CALL:
            begin
                if (req.desc == SPC_DESC_CODE)
                    ok = in_gl(req.tbl) && (req.tgt_dpl == cpl_eff);
                else if (req.desc == SPC_DESC_CGATE && req.op == SPC_OP_CALL)
                begin
                    ok = in_gl(req.tbl) && gate_ok(effective_privilege, req.descriptor_privilege)
                         && gate_dir_ok;
                    lvl_chg = (req.tgt_dpl != cpl_eff);
                    new_cpl = req.tgt_dpl;
                end
                else if (req.desc == SPC_DESC_TSS)
                begin
                    ok = (req.tbl == SPC_TBL_GDT) && (effective_privilege <= req.descriptor_privilege);
                    new_cpl = req.tgt_dpl;
                end
                else if (req.desc == SPC_DESC_TGATE)
                begin
                    ok = in_gl(req.tbl) && gate_ok(effective_privilege, req.descriptor_privilege);
                    new_cpl = req.tgt_dpl;
                end
            end
            SPC_OP_RET, SPC_OP_IRET:
            begin
                if (req.op == SPC_OP_IRET && s_q.nt)
                begin
                    ok = (req.desc == SPC_DESC_TGATE) && (req.tbl == SPC_TBL_IDT);
                    new_cpl = req.tgt_dpl;
                end
                else
                begin
                    ok = (req.desc == SPC_DESC_CODE) && in_gl(req.tbl)
                         && (req.tgt_dpl >= cpl_eff);
                    new_cpl = req.tgt_dpl;
                end
            end
            SPC_OP_INTR:
            begin
                ok = (req.tbl == SPC_TBL_IDT) && gate_ok(effective_privilege, req.descriptor_privilege) &&
                     (req.desc == SPC_DESC_IGATE || req.desc == SPC_DESC_TGATE) &&
                     (req.desc != SPC_DESC_IGATE || gate_dir_ok);
                lvl_chg = (req.desc == SPC_DESC_IGATE) && (req.tgt_dpl != cpl_eff);
                new_cpl = req.tgt_dpl;
            end
            default:
                ok = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.rsp = '0;
        s_d.map_we = 1'b0;
        s_d.rdata = SPC_READ_UNMAPPED;

        if (wr)
        begin
            if (addr == SPC_OFS_MODE)
            begin
                s_d.pe    = wdata[SPC_MODE_PE_BIT];
                s_d.v86   = wdata[SPC_MODE_V86_BIT];
                s_d.tss32 = wdata[SPC_MODE_TSS32_BIT];
            end
            else if (addr == SPC_OFS_FLAGS)
            begin
                s_d.io_privilege_threshold = wdata[SPC_FLAGS_IO_PRIVILEGE_THRESHOLD_LSB +: 2];
                s_d.nt   = wdata[SPC_FLAGS_NT_BIT];
            end
            else if (addr == SPC_OFS_MAPLO)
                s_d.map_lo = wdata;
            else if (addr == SPC_OFS_MAPHI)
            begin
                // top ten bits pick the word, so only 22 upper map bits are loadable
                s_d.map_we = 1'b1;
                s_d.map_waddr = wdata[31:32-SPC_IOMAP_AW];
                s_d.map_wdata = {wdata[31:0] & 32'h003F_FFFF, s_q.map_lo};
            end
        end
        if (rd)
        begin
            // status bit 3 shows a bitmap lookup in progress
            unique case (addr)
                SPC_OFS_MODE:   s_d.rdata = {29'h0, s_q.tss32, s_q.v86, s_q.pe};
                SPC_OFS_STATUS: s_d.rdata = {28'h0, s_q.st == SPC_ST_IOMAP, 1'b0, cpl_eff};
                SPC_OFS_FLAGS:  s_d.rdata = {17'h0, s_q.nt, s_q.io_privilege_threshold, 12'h0};
                default:        s_d.rdata = SPC_READ_UNMAPPED;
            endcase
        end

        unique case (s_q.st)
            SPC_ST_IDLE:
            begin
                if (req.valid && req.op != SPC_OP_NONE)
                begin
                    if (io_op)
                    begin
                        if (io_clear)
                        begin
                            s_d.rsp.done  = 1'b1;
                            s_d.rsp.allow = 1'b1;
                        end
                        else if (s_q.tss32 && req.op == SPC_OP_IO)
                        begin
                            s_d.st   = SPC_ST_IOMAP;
                            s_d.port = req.port;
                        end
                        else
                        begin
                            s_d.rsp.done     = 1'b1;
                            s_d.rsp.gp_fault = 1'b1;
                        end
                    end
                    else
                    begin
                        s_d.rsp.done     = 1'b1;
                        s_d.rsp.allow    = ok;
                        s_d.rsp.gp_fault = !ok;
                        // real and v86 mode never move the held level
                        if (ok && s_q.pe && !s_q.v86 && req.op != SPC_OP_DATA)
                        begin
                            s_d.current_privilege = new_cpl;
                            // only inward moves take a fresh stack from the table
                            if (lvl_chg && new_cpl < cpl_eff)
                            begin
                                s_d.rsp.stack_switch = 1'b1;
                                s_d.rsp.push_old_sp  = 1'b1;
                                s_d.rsp.new_ss       = stk_ss;
                                s_d.rsp.new_sp       = stk_sp;
                            end
                        end
                    end
                end
            end
            SPC_ST_IOMAP:
            begin
                // map word was fetched at the taking edge from the request's port
                s_d.st = SPC_ST_IDLE;
                s_d.rsp.done     = 1'b1;
                s_d.rsp.allow    = !map_bit;
                s_d.rsp.gp_fault = map_bit;
            end
            default:
                s_d.st = SPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            s_q     <= '0;
            s_q.current_privilege <= SPC_CPL_RESET;
        end
        else if (ce)
            s_q <= s_d;
    end

    // -------------------------------------------------------------------
    // sub-blocks
    // -------------------------------------------------------------------
    spc_iomap u_iomap (
        .clock (clock),
        .ce    (ce),
        .we    (s_q.map_we),
        .waddr (s_q.map_waddr),
        .wdata (s_q.map_wdata),
        .raddr (req.port[15:6]),
        .rdata (map_rdata)
    );

    spc_stack_tbl u_stk (
        .clock (clock),
        .rst_n (rst_sync_n),
        .ce    (ce),
        .we    (stk_we),
        .wlvl  (addr[1:0]),
        .wsel  (addr[3]),
        .wdata (wdata),
        .rlvl  (new_cpl),
        .ss    (stk_ss),
        .sp    (stk_sp)
    );

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign rdata           = s_q.rdata;
    assign rsp             = s_q.rsp;
    assign busy            = (s_q.st == SPC_ST_IOMAP);
    assign cur_priv        = cpl_eff;
    assign protected_mode  = s_q.pe;
    assign seg_limit_v86   = SPC_V86_LIMIT;
    assign v86_limit_force = s_q.pe && s_q.v86;
endmodule : spc_checker

// ### spc_chk_asserts.sv
// concurrent checks on the ports of the segment privilege checker
`timescale 1ns/10ps
module spc_chk_asserts (
    input wire logic               clock,
    input wire logic               rst_n,
    input wire logic               ce,
    input wire spc_pkg::spc_req_t  req,
    input wire spc_pkg::spc_rsp_t  rsp,
    input wire logic               busy,
    input wire spc_pkg::spc_priv_t cur_priv,
    input wire logic               protected_mode,
    input wire logic [15:0]        seg_limit_v86,
    input wire logic               v86_limit_force
);
    import spc_pkg::*;
    logic take;
    assign take = ce && req.valid && !busy && (req.op != SPC_OP_NONE);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // -------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------
    property p_data;
        take && req.op == SPC_OP_DATA |=> rsp.done && (rsp.allow ==
            ($past(req.requested_privilege) <= $past(req.descriptor_privilege) && $past(cur_priv) <= $past(req.descriptor_privilege)));
    endproperty
    a_data: assert property (p_data) else $error("data access verdict wrong");
    property p_data_cpl;
        take && req.op == SPC_OP_DATA |=> $stable(cur_priv);
    endproperty
    a_data_cpl: assert property (p_data_cpl) else $error("data access moved level");
    property p_real_zero;
        !protected_mode |-> cur_priv == SPC_PRIV_MOST;
    endproperty
    a_real_zero: assert property (p_real_zero) else $error("real mode level not 0");
    property p_busy;
        $rose(busy) |=> !busy && rsp.done;
    endproperty
    a_busy: assert property (p_busy) else $error("bitmap lookup length wrong");
    property p_ifmod;
        take && req.op == SPC_OP_IFMOD |=> rsp.done && !busy;
    endproperty
    a_ifmod: assert property (p_ifmod) else $error("flag change used bitmap");
    property p_jmp_gate;
        take && protected_mode && req.op == SPC_OP_JMP && req.desc == SPC_DESC_CGATE
            |=> rsp.gp_fault;
    endproperty
    a_jmp_gate: assert property (p_jmp_gate) else $error("jump via gate passed");
    property p_gate_priv;
        take && protected_mode && req.op == SPC_OP_CALL && req.desc == SPC_DESC_CGATE
            && req.requested_privilege > req.descriptor_privilege |=> rsp.gp_fault;
    endproperty
    a_gate_priv: assert property (p_gate_priv) else $error("gate level ignored");
    property p_intr_tbl;
        take && protected_mode && req.op == SPC_OP_INTR && req.tbl != SPC_TBL_IDT
            |=> rsp.gp_fault;
    endproperty
    a_intr_tbl: assert property (p_intr_tbl) else $error("interrupt outside table");
    property p_fault;
        rsp.gp_fault |-> rsp.done && !rsp.allow && $stable(cur_priv);
    endproperty
    a_fault: assert property (p_fault) else $error("fault not clean");
    property p_stack;
        rsp.stack_switch |-> rsp.push_old_sp && rsp.allow;
    endproperty
    a_stack: assert property (p_stack) else $error("stack switch without push");
    property p_v86;
        v86_limit_force |-> cur_priv == SPC_PRIV_LEAST && seg_limit_v86 == SPC_V86_LIMIT;
    endproperty
    a_v86: assert property (p_v86) else $error("v86 level or limit wrong");
endmodule : spc_chk_asserts

bind spc_checker spc_chk_asserts u_chk (
    .clock(clock), .rst_n(rst_n), .ce(ce), .req(req), .rsp(rsp), .busy(busy),
    .cur_priv(cur_priv), .protected_mode(protected_mode),
    .seg_limit_v86(seg_limit_v86), .v86_limit_force(v86_limit_force)
);

// ### spc_pipe_model.sv
// request issuer standing in for the execution pipeline
`timescale 1ns/10ps
module spc_pipe_model (
    input  wire logic              clock,
    input  wire logic              busy,
    input  wire spc_pkg::spc_rsp_t rsp,
    output spc_pkg::spc_req_t      req
);
    import spc_pkg::*;
    initial req = '0;
    // fields other than valid stay put until the answer, then the port is scrambled
    task automatic issue(input spc_req_t r, output spc_rsp_t s, output bit ok);
        int n;
        ok = 1'b0;
        s = '0;
        @(posedge clock);
        req <= r;
        @(posedge clock);
        req.valid <= 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (rsp.done === 1'b1 && busy === 1'b0)
            begin
                s = rsp;
                ok = 1'b1;
            end
            else
                @(posedge clock);
        end
        @(posedge clock);
        req.port <= ~r.port;
    endtask : issue
endmodule : spc_pipe_model

// ### tb_top.sv
// self-checking bench for the segment privilege checker
`timescale 1ns/10ps
module tb_top;
    import spc_pkg::*;
    logic        clock;
    logic        rst_n;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    spc_req_t    req;
    spc_rsp_t    rsp;
    spc_rsp_t    s;
    logic        busy;
    spc_priv_t   cur_priv;
    logic        protected_mode;
    logic [15:0] seg_limit_v86;
    logic        v86_limit_force;
    int          n_fail;
    int          n_tests;
    int          i;

    spc_checker dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .req(req), .rsp(rsp), .busy(busy),
        .cur_priv(cur_priv), .protected_mode(protected_mode),
        .seg_limit_v86(seg_limit_v86), .v86_limit_force(v86_limit_force));
    spc_pipe_model pm (.clock(clock), .busy(busy), .rsp(rsp), .req(req));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // -------------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------------
    task automatic wrap_up();
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask : rd_chk
    task automatic run(input spc_op_t op, input spc_priv_t rl, input spc_priv_t dl,
        input spc_desc_t d, input spc_tbl_t t, input spc_priv_t tg, input logic [15:0] p,
        input logic a);
        bit ok;
        pm.issue({1'b1, op, rl, dl, d, t, tg, p}, s, ok);
        if (!ok)
        begin
            n_fail++;
            $display("CHECK FAILED answer expected done seen none");
            wrap_up();
        end
        else
        begin
            chk("allow", {31'h0, s.allow}, {31'h0, a});
            chk("gp_fault", {31'h0, s.gp_fault}, {31'h0, !a});
        end
    endtask : run
    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial
    begin
        n_fail = 0;
        n_tests = 0;
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk("pe", {31'h0, protected_mode}, 32'h0);
        rd_chk(SPC_OFS_MODE, 32'h0);
        run(SPC_OP_DATA, 2'h3, 2'h0, SPC_DESC_DATA, SPC_TBL_GDT, 2'h0, 16'h0, 1'b0);
        wr_reg(SPC_OFS_MODE, 32'h1);
        #1;
        chk("pe", {31'h0, protected_mode}, 32'h1);
        for (i = 0; i < 4; i++)
            run(SPC_OP_DATA, 2'(i), 2'(3 - i), SPC_DESC_DATA, SPC_TBL_LDT, 2'h0, 16'h0,
                i < 2);
        wr_reg(SPC_OFS_STK0, 32'h0000_1000);
        wr_reg(SPC_OFS_SEL0, 32'h0000_0010);
        wr_reg(SPC_OFS_MAPLO, 32'h0000_0020);
        wr_reg(SPC_OFS_MAPHI, 32'h0000_0000);
        run(SPC_OP_IO, 2'h0, 2'h0, SPC_DESC_DATA, SPC_TBL_GDT, 2'h0, 16'h5, 1'b1);
        run(SPC_OP_RET, 2'h3, 2'h3, SPC_DESC_CODE, SPC_TBL_GDT, 2'h3, 16'h0, 1'b1);
        chk("cur_priv", {30'h0, cur_priv}, 32'h3);
        rd_chk(SPC_OFS_STATUS, 32'h3);
        run(SPC_OP_JMP, 2'h3, 2'h3, SPC_DESC_CODE, SPC_TBL_LDT, 2'h3, 16'h0, 1'b1);
        run(SPC_OP_JMP, 2'h3, 2'h3, SPC_DESC_CODE, SPC_TBL_IDT, 2'h3, 16'h0, 1'b0);
        run(SPC_OP_JMP, 2'h3, 2'h3, SPC_DESC_CGATE, SPC_TBL_GDT, 2'h3, 16'h0, 1'b0);
        run(SPC_OP_IO, 2'h3, 2'h3, SPC_DESC_DATA, SPC_TBL_GDT, 2'h3, 16'h4, 1'b0);
        run(SPC_OP_IFMOD, 2'h3, 2'h3, SPC_DESC_DATA, SPC_TBL_GDT, 2'h3, 16'h0, 1'b0);
        wr_reg(SPC_OFS_FLAGS, 32'h0000_3000);
        run(SPC_OP_IFMOD, 2'h3, 2'h3, SPC_DESC_DATA, SPC_TBL_GDT, 2'h3, 16'h0, 1'b1);
        wr_reg(SPC_OFS_FLAGS, 32'h0);
        wr_reg(SPC_OFS_MODE, 32'h5);
        run(SPC_OP_IO, 2'h3, 2'h3, SPC_DESC_DATA, SPC_TBL_GDT, 2'h3, 16'h5, 1'b0);
        run(SPC_OP_IO, 2'h3, 2'h3, SPC_DESC_DATA, SPC_TBL_GDT, 2'h3, 16'h4, 1'b1);
        run(SPC_OP_IFMOD, 2'h3, 2'h3, SPC_DESC_DATA, SPC_TBL_GDT, 2'h3, 16'h0, 1'b0);
        run(SPC_OP_CALL, 2'h3, 2'h2, SPC_DESC_CGATE, SPC_TBL_GDT, 2'h0, 16'h0, 1'b0);
        run(SPC_OP_CALL, 2'h3, 2'h3, SPC_DESC_CGATE, SPC_TBL_LDT, 2'h0, 16'h0, 1'b1);
        chk("stack_switch", {31'h0, s.stack_switch}, 32'h1);
        chk("new_ss", {16'h0, s.new_ss}, 32'h0000_0010);
        chk("new_sp", s.new_sp, 32'h0000_1000);
        chk("push_old_sp", {31'h0, s.push_old_sp}, 32'h1);
        chk("cur_priv", {30'h0, cur_priv}, 32'h0);
        run(SPC_OP_CALL, 2'h0, 2'h3, SPC_DESC_CGATE, SPC_TBL_GDT, 2'h3, 16'h0, 1'b0);
        run(SPC_OP_INTR, 2'h0, 2'h3, SPC_DESC_IGATE, SPC_TBL_GDT, 2'h0, 16'h0, 1'b0);
        run(SPC_OP_INTR, 2'h0, 2'h3, SPC_DESC_IGATE, SPC_TBL_IDT, 2'h0, 16'h0, 1'b1);
        run(SPC_OP_INTR, 2'h0, 2'h3, SPC_DESC_IGATE, SPC_TBL_IDT, 2'h3, 16'h0, 1'b0);
        run(SPC_OP_JMP, 2'h0, 2'h3, SPC_DESC_TSS, SPC_TBL_GDT, 2'h0, 16'h0, 1'b1);
        run(SPC_OP_CALL, 2'h0, 2'h3, SPC_DESC_TSS, SPC_TBL_LDT, 2'h0, 16'h0, 1'b0);
        run(SPC_OP_CALL, 2'h0, 2'h3, SPC_DESC_TGATE, SPC_TBL_LDT, 2'h0, 16'h0, 1'b1);
        wr_reg(SPC_OFS_FLAGS, 32'h0000_4000);
        run(SPC_OP_IRET, 2'h0, 2'h3, SPC_DESC_TGATE, SPC_TBL_IDT, 2'h0, 16'h0, 1'b1);
        wr_reg(SPC_OFS_MODE, 32'h3);
        #1;
        chk("cur_priv", {30'h0, cur_priv}, 32'h3);
        chk("limit", {15'h0, v86_limit_force, seg_limit_v86}, 32'h0001_FFFF);
        rd_chk(4'hF, SPC_READ_UNMAPPED);
        wrap_up();
    end
endmodule : tb_top
